// ==== rtl/machine_phase.v ====
`timescale 1ns/10ps
`default_nettype none
`include "power_saving_defs.vh"

// free-running phase counter over one machine cycle, advanced by a tick
module machine_phase (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// advance
	input wire i_tick,
	// phase state
	output reg [3:0] o_phase,
	output wire o_cycle_end,
	output wire o_s3p1
);

	assign o_cycle_end = i_tick && (o_phase == `OSC_PER_CYCLE - 4'h1);
	assign o_s3p1 = i_tick && (o_phase == `PHASE_S3P1);

	always @(posedge i_clk_sys) begin
		if (!i_rst_n)
			o_phase <= 4'h0;
		else if (o_cycle_end)
			o_phase <= 4'h0;
		else if (i_tick)
			o_phase <= o_phase + 4'h1;
	end

endmodule // machine_phase
`default_nettype wire

// ==== rtl/power_saving_defs.vh ====
`ifndef POWER_SAVING_DEFS_VH
`define POWER_SAVING_DEFS_VH

// register map (8-bit special function register space)
`define PWR_ADDR_W 8
`define PWR_CONTROL_ADDR 8'h87
`define PWR_STATUS_ADDR 8'hA7

// power_control bit positions
`define BIT_IDLE_ENABLE 0
`define BIT_POWERDOWN_ENABLE 1
`define BIT_USER_FLAG_ZERO 2
`define BIT_USER_FLAG_ONE 3
`define BIT_SLOW_DOWN 4
`define BIT_IDLE_START 5
`define BIT_POWERDOWN_START 6

// power_status bit positions
`define ST_IDLE 0
`define ST_POWERDOWN 1
`define ST_SLOW 2
`define ST_ENABLE 3

// machine cycle: 12 oscillator periods, 6 states of 2 phases
`define OSC_PER_CYCLE 4'hC
`define PHASE_S3P1 4'h4
`define SLOW_DIVIDE 3'h7
`define SYNC_CYCLES 2'h2

`endif

// ==== rtl/power_saving_mode_control.v ====
// Summary of operation
// - watchdog clock enable drops during idle; peripherals keep running.
// - modes take effect only while the enable pin is low.
// - enable and start in one write never enter idle; both read zero.
// - the start write completes, then idle begins before the next instruction.
// - any enabled interrupt ends idle and restores the processor clock.
// - hardware reset ends idle; two machine cycles suffice while oscillator runs.
// - from external code, low port floats; high port shows address in idle.
// - power-down stops oscillator; strobes and clock output held low.
// - power-down enable and start in one write never enter; both read zero.
// - power-down follows the start write; it wins over idle.
// - only hardware reset leaves power-down; registers reset, RAM kept.
// - that reset restarts the oscillator; caller holds it long enough.
// - slow mode divides every derived clock by eight, clock output too.
// - slow mode takes effect within two machine cycles of setting the bit.
// - slow mode combines with idle and power-down; clearing returns full speed.
// - two user flags store written values and steer nothing.
// - with enable pin high, entry sequences are ignored entirely.
// - in idle, address latch and program store strobes are held high.
// - enable pin level is sampled at state 3 phase 1 through a filter.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "power_saving_defs.vh"

module power_saving_mode_control (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// register port
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	// system pins and core status
	input wire i_power_save_enable_pin_n,
	input wire i_irq_pending,
	input wire i_ext_code,
	input wire i_ale_run,
	input wire i_program_store_strobe_run,
	// clock enables
	output reg o_cpu_clk_en,
	output reg o_periph_clk_en,
	output reg o_wdt_clk_en,
	output reg o_osc_stop,
	output reg o_clock_output_pin,
	// pin control
	output reg o_ale,
	output reg o_program_store_strobe,
	output reg o_port0_float,
	output reg o_port2_address,
	output reg o_ports_freeze,
	// mode status
	output reg o_idle,
	output reg o_powerdown,
	output reg o_slow
);

	//----------------------------------------
	// mode states
	//----------------------------------------
	localparam ST_RUN = 2'b00;
	localparam ST_IDLE = 2'b01;
	localparam ST_PDOWN = 2'b10;

	reg [1:0] state_reg, state_next;
	reg idle_armed_reg, pd_armed_reg;
	reg user_flag_zero_reg, user_flag_one_reg, slow_down_bit_reg;
	reg [2:0] filt_reg;
	reg enable_reg;
	reg [1:0] sync_cnt_reg;
	reg slow_reg;
	reg clock_output_pin_reg;

	wire tick;
	wire cycle_end;
	wire s3p1;
	wire [3:0] phase;
	wire power_control_wr = i_wr && (i_addr == `PWR_CONTROL_ADDR);
	wire pin_low = !i_power_save_enable_pin_n;
	wire w_idle_en = i_wdata[`BIT_IDLE_ENABLE];
	wire w_idle_st = i_wdata[`BIT_IDLE_START];
	wire w_pd_en = i_wdata[`BIT_POWERDOWN_ENABLE];
	wire w_pd_st = i_wdata[`BIT_POWERDOWN_START];
	wire go_idle = power_control_wr && enable_reg && idle_armed_reg && w_idle_st && !w_idle_en;
	wire go_pd = power_control_wr && enable_reg && pd_armed_reg && w_pd_st && !w_pd_en;

	//----------------------------------------
	// timebase
	//----------------------------------------
	// the oscillator only stops in power-down, which only reset leaves
	slow_divider u_div (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_slow(slow_reg),
		.i_run(state_reg != ST_PDOWN),
		.o_tick(tick)
	);

	machine_phase u_phase (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_tick(tick),
		.o_phase(phase),
		.o_cycle_end(cycle_end),
		.o_s3p1(s3p1)
	);

	//----------------------------------------
	// enable pin filter
	//----------------------------------------
	// three-sample majority stands in for the schmitt input; the level is
	// only accepted at state 3 phase 1
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			filt_reg <= 3'h0;
			enable_reg <= 1'b0;
		end else begin
			filt_reg <= {filt_reg[1:0], pin_low};
			if (s3p1)
				enable_reg <= (filt_reg[0] & filt_reg[1]) | (filt_reg[1] & filt_reg[2])
					| (filt_reg[0] & filt_reg[2]);
		end
	end

	//----------------------------------------
	// power_control register
	//----------------------------------------
	// arm bits only live until the very next power_control write, so any other
	// write to it in between breaks the double-write sequence
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			idle_armed_reg <= 1'b0;
			pd_armed_reg <= 1'b0;
			user_flag_zero_reg <= 1'b0;
			user_flag_one_reg <= 1'b0;
			slow_down_bit_reg <= 1'b0;
		end else if (power_control_wr) begin
			// both in one write arms nothing
			idle_armed_reg <= enable_reg && w_idle_en && !w_idle_st;
			pd_armed_reg <= enable_reg && w_pd_en && !w_pd_st;
			user_flag_zero_reg <= i_wdata[`BIT_USER_FLAG_ZERO];
			user_flag_one_reg <= i_wdata[`BIT_USER_FLAG_ONE];
			slow_down_bit_reg <= i_wdata[`BIT_SLOW_DOWN];
		end
	end

	// read data: enable and start bits always read zero
	always @(posedge i_clk_sys) begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else if (i_rd && i_addr == `PWR_CONTROL_ADDR) begin
			o_rdata <= 8'h00;
			o_rdata[`BIT_USER_FLAG_ZERO] <= user_flag_zero_reg;
			o_rdata[`BIT_USER_FLAG_ONE] <= user_flag_one_reg;
			o_rdata[`BIT_SLOW_DOWN] <= slow_down_bit_reg;
		end else if (i_rd && i_addr == `PWR_STATUS_ADDR) begin
			o_rdata <= 8'h00;
			o_rdata[`ST_IDLE] <= (state_reg == ST_IDLE);
			o_rdata[`ST_POWERDOWN] <= (state_reg == ST_PDOWN);
			o_rdata[`ST_SLOW] <= slow_reg;
			o_rdata[`ST_ENABLE] <= enable_reg;
		end else
			o_rdata <= 8'h00;
	end

	//----------------------------------------
	// mode state machine
	//----------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (go_pd)
					state_next = ST_PDOWN;
				else if (go_idle)
					state_next = ST_IDLE;
			end
			ST_IDLE: begin
				if (i_irq_pending)
					state_next = ST_RUN;
			end
			ST_PDOWN: begin
				state_next = ST_PDOWN;
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// synchronous reset leaves idle and power-down at once
	always @(posedge i_clk_sys) begin
		if (!i_rst_n)
			state_reg <= ST_RUN;
		else
			state_reg <= state_next;
	end

	//----------------------------------------
	// slow-down synchronisation
	//----------------------------------------
	// the divider only changes ratio on a machine cycle boundary, after
	// the request has stayed stable across two successive boundaries
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			slow_reg <= 1'b0;
			sync_cnt_reg <= 2'h0;
		end else begin
			if ((slow_down_bit_reg && enable_reg) == slow_reg)
				sync_cnt_reg <= 2'h0;
			else if (cycle_end) begin
				if (sync_cnt_reg == `SYNC_CYCLES - 2'h1) begin
					slow_reg <= !slow_reg;
					sync_cnt_reg <= 2'h0;
				end else
					sync_cnt_reg <= sync_cnt_reg + 2'h1;
			end
		end
	end

	//----------------------------------------
	// clock output
	//----------------------------------------
	// high for phases 0 to 6 of each machine cycle (7 of 12), follows the divided tick
	always @(posedge i_clk_sys) begin
		if (!i_rst_n)
			clock_output_pin_reg <= 1'b0;
		else if (state_next == ST_PDOWN)
			clock_output_pin_reg <= 1'b0;
		else if (tick)
			clock_output_pin_reg <= (phase < (`OSC_PER_CYCLE >> 1)) ^ cycle_end;
	end

	//----------------------------------------
	// output registers
	//----------------------------------------
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_cpu_clk_en <= 1'b0;
			o_periph_clk_en <= 1'b0;
			o_wdt_clk_en <= 1'b0;
			o_osc_stop <= 1'b0;
			o_clock_output_pin <= 1'b0;
			o_ale <= 1'b0;
			o_program_store_strobe <= 1'b0;
			o_port0_float <= 1'b0;
			o_port2_address <= 1'b0;
			o_ports_freeze <= 1'b0;
			o_idle <= 1'b0;
			o_powerdown <= 1'b0;
			o_slow <= 1'b0;
		end else begin
			// enables are single-cycle pulses per tick, so gating is glitch-free
			o_cpu_clk_en <= tick && state_next == ST_RUN;
			o_periph_clk_en <= tick && state_next != ST_PDOWN;
			o_wdt_clk_en <= tick && state_next == ST_RUN;
			o_osc_stop <= state_next == ST_PDOWN;
			// stop low in the same cycle that power-down begins
			o_clock_output_pin <= clock_output_pin_reg && state_next != ST_PDOWN;
			o_ports_freeze <= state_next == ST_PDOWN;
			o_idle <= state_next == ST_IDLE;
			o_powerdown <= state_next == ST_PDOWN;
			o_slow <= slow_reg;
			case (state_next)
				ST_IDLE: begin
					o_ale <= 1'b1;
					o_program_store_strobe <= 1'b1;
					o_port0_float <= i_ext_code;
					o_port2_address <= i_ext_code;
				end
				ST_PDOWN: begin
					o_ale <= 1'b0;
					o_program_store_strobe <= 1'b0;
					o_port0_float <= i_ext_code;
					o_port2_address <= 1'b0;
				end
				default: begin
					o_ale <= i_ale_run;
					o_program_store_strobe <= i_program_store_strobe_run;
					o_port0_float <= 1'b0;
					o_port2_address <= i_ext_code;
				end
			endcase
		end
	end

endmodule // power_saving_mode_control
`default_nettype wire

// ==== rtl/slow_divider.v ====
`timescale 1ns/10ps
`default_nettype none
`include "power_saving_defs.vh"

// divide-by-eight tick generator: one tick per oscillator edge at full
// speed, one per eight when slow mode is on
module slow_divider (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// control
	input wire i_slow,
	input wire i_run,
	// tick
	output wire o_tick
);

	reg [2:0] div_reg;

	assign o_tick = i_run && (!i_slow || div_reg == `SLOW_DIVIDE);

	always @(posedge i_clk_sys) begin
		if (!i_rst_n)
			div_reg <= 3'h0;
		else if (!i_run || !i_slow)
			div_reg <= 3'h0;
		else
			div_reg <= div_reg + 3'h1;
	end

endmodule // slow_divider
`default_nettype wire

// ==== test/cpu_side_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model #(
	parameter int WAKE_DELAY = 5
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// control
	input wire logic i_wake,
	input wire logic i_idle,
	// to the block
	output logic o_irq_pending,
	output logic o_ale_run,
	output logic o_strobe_run
);
	int cnt;
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			cnt <= 0;
			o_irq_pending <= 1'b0;
			o_ale_run <= 1'b0;
			o_strobe_run <= 1'b0;
		end else begin
			o_ale_run <= ~o_ale_run;
			o_strobe_run <= o_ale_run;
			// a level request held until the core runs again, never a short pulse
			if (o_irq_pending && !i_idle)
				o_irq_pending <= 1'b0;
			else if (i_wake && i_idle) begin
				cnt <= cnt + 1;
				if (cnt == WAKE_DELAY)
					o_irq_pending <= 1'b1;
			end else
				cnt <= 0;
		end
	end
endmodule // cpu_side_model
`default_nettype wire

// ==== test/power_saving_mode_control_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module power_saving_mode_control_checker (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// core side
	input wire logic i_irq_pending,
	input wire logic i_ext_code,
	// observed outputs
	input wire logic o_cpu_clk_en,
	input wire logic o_wdt_clk_en,
	input wire logic o_osc_stop,
	input wire logic o_clock_output_pin,
	input wire logic o_ale,
	input wire logic o_program_store_strobe,
	input wire logic o_port0_float,
	input wire logic o_port2_address,
	input wire logic o_idle,
	input wire logic o_powerdown
);
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_ctl_rd;
		i_rd && i_addr == 8'h87;
	endsequence
	sequence s_idle_both;
		i_wr && i_addr == 8'h87 && i_wdata[0] && i_wdata[5];
	endsequence
	AST_WDT_IDLE: assert property (o_idle |-> !o_wdt_clk_en && !o_cpu_clk_en)
		else $error("watchdog or cpu clocked in idle");
	AST_IDLE_PINS: assert property (o_idle && !o_powerdown |-> o_ale && o_program_store_strobe)
		else $error("strobes not high in idle");
	AST_PD_PINS: assert property (o_powerdown |-> !o_ale && !o_program_store_strobe
		&& !o_clock_output_pin && o_osc_stop) else $error("pins wrong in power-down");
	AST_PORTS: assert property (o_idle && $past(o_idle) && $stable(i_ext_code)
		|-> o_port0_float == i_ext_code && o_port2_address == i_ext_code)
		else $error("port control wrong in idle");
	AST_IRQ_EXIT: assert property (o_idle && !o_powerdown && i_irq_pending |=> !o_idle)
		else $error("idle kept with interrupt pending");
	AST_PD_HOLD: assert property (o_powerdown |=> o_powerdown)
		else $error("power-down left without reset");
	AST_NO_SINGLE: assert property (!o_idle ##0 s_idle_both |=> !o_idle)
		else $error("single write entered idle");
	AST_RD_ZERO: assert property (s_ctl_rd |=> (o_rdata & 8'h63) == 8'h00)
		else $error("enable or start bit read as one");
endmodule // power_saving_mode_control_checker

bind power_saving_mode_control power_saving_mode_control_checker u_chk (.*);
`default_nettype wire

// ==== test/power_saving_mode_control_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module power_saving_mode_control_tb_top;
	logic i_clk_sys, i_rst_n, i_wr, i_rd, i_power_save_enable_pin_n, i_irq_pending;
	logic i_ext_code, i_ale_run, i_program_store_strobe_run, wake;
	logic [7:0] i_addr, i_wdata, o_rdata;
	logic o_cpu_clk_en, o_periph_clk_en, o_wdt_clk_en, o_osc_stop, o_clock_output_pin;
	logic o_ale, o_program_store_strobe, o_port0_float, o_port2_address, o_ports_freeze;
	logic o_idle, o_powerdown, o_slow;
	int miscompares, n_tests, cyc, k, cnt;
	int flags_m;
	logic [31:0] seed;
	power_saving_mode_control DUT (.*);
	cpu_side_model u_cpu (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wake(wake),
		.i_idle(o_idle), .o_irq_pending(i_irq_pending), .o_ale_run(i_ale_run),
		.o_strobe_run(i_program_store_strobe_run));
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	// ----------------------------------------
	// bus tasks and compares
	// ----------------------------------------
	task conclude;
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask
	// strobe stays up so back-to-back writes never assign twice in one step
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_rd <= 1'b0;
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
	endtask
	task nop;
		i_wr <= 1'b0;
		@(posedge i_clk_sys);
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		// read data stand only in the cycle after the strobe
		#1;
		chk8(o_rdata, e);
		@(posedge i_clk_sys);
	endtask
	task w(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			conclude;
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		seed = 32'hb0008de9;
		{i_rst_n, i_wr, i_rd, wake, i_addr, i_wdata} = '0;
		i_power_save_enable_pin_n = 1'b0;
		i_ext_code = $random(seed);
		repeat (10) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		w(40);
		flags_m = $random(seed) & 8'h0C;
		wr(8'h87, flags_m[7:0]);
		rd(8'h87, flags_m[7:0]);
		rd(8'h55, 8'h00);
		wr(8'h87, flags_m[7:0] | 8'h21);
		nop;
		w(2);
		chk1(o_idle, 1'b0);
		wr(8'h87, flags_m[7:0] | 8'h01);
		wr(8'h87, flags_m[7:0] | 8'h20);
		nop;
		chk1(o_idle, 1'b1);
		chk1(o_periph_clk_en | o_slow, 1'b1);
		wake <= 1'b1;
		for (k = 0; k < 40 && o_idle !== 1'b0; k++) w(1);
		chk1(o_idle, 1'b0);
		wake <= 1'b0;
		w(2);
		chk1(o_cpu_clk_en, 1'b1);
		rd(8'h87, flags_m[7:0]);
		i_power_save_enable_pin_n <= 1'b1;
		w(40);
		wr(8'h87, 8'h01);
		wr(8'h87, 8'h20);
		nop;
		w(2);
		chk1(o_idle, 1'b0);
		i_power_save_enable_pin_n <= 1'b0;
		w(40);
		wr(8'h87, flags_m[7:0] | 8'h10);
		nop;
		for (k = 0; k < 40 && o_slow !== 1'b1; k++) w(1);
		chk1(k <= 26, 1'b1);
		for (cnt = 0, k = 0; k < 80; k++) begin
			w(1);
			cnt += o_cpu_clk_en;
		end
		chk1(cnt >= 9 && cnt <= 11, 1'b1);
		rd(8'h87, flags_m[7:0] | 8'h10);
		wr(8'h87, flags_m[7:0]);
		nop;
		// leaving slow mode syncs on slow machine cycles of 96 clocks each
		for (k = 0; k < 200 && o_slow !== 1'b0; k++) w(1);
		chk1(o_slow, 1'b0);
		wr(8'h87, flags_m[7:0] | 8'h42);
		nop;
		w(2);
		chk1(o_powerdown, 1'b0);
		wr(8'h87, flags_m[7:0] | 8'h03);
		wr(8'h87, flags_m[7:0] | 8'h60);
		nop;
		chk1(o_powerdown, 1'b1);
		chk1(o_idle, 1'b0);
		chk1(o_osc_stop, 1'b1);
		w(20);
		chk1(o_powerdown, 1'b1);
		i_rst_n <= 1'b0;
		w(24);
		i_rst_n <= 1'b1;
		w(2);
		chk1(o_powerdown, 1'b0);
		chk1(o_osc_stop, 1'b0);
		rd(8'h87, 8'h00);
		conclude;
	end
endmodule // power_saving_mode_control_tb_top
`default_nettype wire
